// *** sfpx_cfg.svh ***
`ifndef SFPX_CFG_SVH
`define SFPX_CFG_SVH

// register byte offsets
`define SFPX_OFF_CTRLSTAT 8'h00
`define SFPX_OFF_PFLAGS 8'h04
`define SFPX_OFF_IRQ_STS 8'h08
`define SFPX_OFF_IRQ_MSK 8'h0C
`define SFPX_OFF_TRAP_INFO 8'h10

// control/status field layout
`define SFPX_FLAG_LSB 0
`define SFPX_FLAG_MSB 5
`define SFPX_MASK_LSB 7
`define SFPX_MASK_MSB 12

// exception bit positions inside a six-bit group
`define SFPX_EXC_INVALID 0
`define SFPX_EXC_DENORM 1
`define SFPX_EXC_DIVZERO 2
`define SFPX_EXC_OVERFLOW 3
`define SFPX_EXC_UNDERFLOW 4
`define SFPX_EXC_INEXACT 5
`define SFPX_PRE_SET 6'h07
`define SFPX_POST_SET 6'h38

// processor flags register: interrupt enable bit
`define SFPX_PF_IF_BIT 9
`define SFPX_PF_IF_RST 1'h0

// trap info layout
`define SFPX_TI_CAUSE_LSB 0
`define SFPX_TI_CAUSE_MSB 5
`define SFPX_TI_FAULT_BIT 6
`define SFPX_TI_VEC_LSB 8
`define SFPX_TI_VEC_MSB 15

// interrupt status bits
`define SFPX_IRQ_MASKED 0
`define SFPX_IRQ_TRAP 1

// reset values and constants
`define SFPX_MASK_RST 6'h3F
`define SFPX_FLAG_RST 6'h00
`define SFPX_IRQ_MSK_RST 2'h0
`define SFPX_TRAP_VECTOR 8'h13
`define SFPX_LANES 4
`define SFPX_NEXC 6

`endif

// *** sfpx_pkg.sv ***
package sfpx_pkg;
	typedef logic [5:0] sfpx_exc_t;
	typedef logic [31:0] sfpx_word_t;

	typedef enum logic [1:0] {
		SFPX_RES_NONE = 2'h0,
		SFPX_RES_COMMIT = 2'h1,
		SFPX_RES_SUPPRESS = 2'h2
	} sfpx_res_e;

	typedef struct packed {
		sfpx_exc_t flags_q;
		sfpx_exc_t masks_q;
		logic if_q;
		logic [1:0] irq_sts_q;
		logic [1:0] irq_msk_q;
		sfpx_exc_t cause_q;
		logic fault_q;
		logic trap_q;
		sfpx_res_e res_q;
		logic if_clr_q;
		logic irq_q;
		sfpx_word_t rdata_q;
	} sfpx_state_s;
endpackage

// *** sfpx_comb_if.sv ***
`timescale 1ns/1ps
interface sfpx_comb_if;
	logic [3:0][5:0] lane_exc;
	logic [3:0] lane_en;
	logic packed_op;
	logic [5:0] any_exc;
	logic [5:0] pre_exc;
	logic [5:0] post_exc;

	modport src (output lane_exc, lane_en, packed_op, input any_exc, pre_exc, post_exc);
	modport comb (input lane_exc, lane_en, packed_op, output any_exc, pre_exc, post_exc);
endinterface

// *** sfpx_lane_or.sv ***
`timescale 1ns/1ps
`include "sfpx_cfg.svh"
// merges per-lane exception reports into one flag set and splits it by class
module sfpx_lane_or (
	sfpx_comb_if.comb c
);
	// packed ops OR every enabled lane; scalar ops look at lane 0 only
	always_comb begin
		c.any_exc = `SFPX_FLAG_RST;
		for (int i = 0; i < `SFPX_LANES; i++) begin
			if (c.lane_en[i] && (c.packed_op || i == 0)) begin
				c.any_exc = c.any_exc | c.lane_exc[i];
			end
		end
	end

	// faults are seen before computing, traps after
	assign c.pre_exc = c.any_exc & `SFPX_PRE_SET;
	assign c.post_exc = c.any_exc & `SFPX_POST_SET;
endmodule

// *** sfpx_exc_unit.sv ***
// Function
// - masked exception: default result, sticky flag set, no trap
// - one flag per exception type shared by all lanes
// - packed flags are the OR of every enabled lane's flags
// - unmasked exception traps through vector 19
// - an old sticky flag never traps; only new unmasked conditions
// - trap is precise, at the faulting instruction, never deferred
// - ops may overlap other work with no sync step
// - entry through an interrupt gate clears the interrupt enable flag
// - invalid, divzero, denormal are faults; overflow, underflow, inexact traps
// - unmasked post-computation trap supplies no rounded result
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "sfpx_cfg.svh"
module sfpx_exc_unit (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_op_valid,
	input wire logic i_op_packed,
	input wire logic [3:0] i_lane_en,
	input wire logic [3:0][5:0] i_lane_exc,
	input wire logic i_gate_is_intr,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_trap,
	output logic [7:0] o_trap_vector,
	output logic [5:0] o_trap_cause,
	output logic o_trap_fault,
	output logic o_res_commit,
	output logic o_res_suppress,
	output logic o_if_clear,
	output logic o_irq
);
	sfpx_pkg::sfpx_state_s s_q;
	sfpx_pkg::sfpx_state_s s_d;
	sfpx_comb_if comb_if ();

	logic op_take;
	logic [5:0] raised;
	logic [5:0] unmasked;
	logic [5:0] pre_unmasked;
	logic take_trap;
	logic masked_event;
	logic [1:0] irq_set;

	// address decode shared by read and write paths
	function automatic logic sel(input logic [7:0] addr, input logic [7:0] off);
		sel = (addr == off);
	endfunction

	// write-one-to-clear with set winning over a same-cycle clear
	function automatic logic [1:0] w1c(input logic [1:0] cur, input logic [1:0] clr,
		input logic [1:0] set);
		w1c = (cur & ~clr) | set;
	endfunction

	// control/status word as software sees it
	function automatic sfpx_pkg::sfpx_word_t cs_word(input logic [5:0] flags,
		input logic [5:0] masks);
		cs_word = 32'h0000_0000;
		cs_word[`SFPX_FLAG_MSB:`SFPX_FLAG_LSB] = flags;
		cs_word[`SFPX_MASK_MSB:`SFPX_MASK_LSB] = masks;
	endfunction

	assign comb_if.lane_exc = i_lane_exc;
	assign comb_if.lane_en = i_lane_en;
	assign comb_if.packed_op = i_op_packed;

	sfpx_lane_or u_lane_or (
		.c(comb_if.comb)
	);

	// an op in the cycle the trap is presented belongs to a younger
	// instruction that the core flushes, so it is dropped here
	assign op_take = i_op_valid && !s_q.trap_q;

	// a pre-computation fault that is unmasked stops the op before the
	// arithmetic runs, so post-computation conditions are never seen
	assign pre_unmasked = comb_if.pre_exc & ~s_q.masks_q;
	always_comb begin
		if (pre_unmasked != `SFPX_FLAG_RST) begin
			raised = comb_if.pre_exc;
		end else begin
			raised = comb_if.any_exc;
		end
	end

	// only conditions raised by this op are compared with the mask; the
	// sticky flags take no part, so stale flags never trap
	assign unmasked = raised & ~s_q.masks_q;
	assign take_trap = op_take && (unmasked != `SFPX_FLAG_RST);
	assign masked_event = op_take && !take_trap && (raised != `SFPX_FLAG_RST);

	always_comb begin
		irq_set = 2'h0;
		irq_set[`SFPX_IRQ_MASKED] = masked_event;
		irq_set[`SFPX_IRQ_TRAP] = take_trap;
	end

	// next state
	always_comb begin
		s_d = s_q;
		s_d.trap_q = 1'h0;
		s_d.if_clr_q = 1'h0;
		s_d.res_q = sfpx_pkg::SFPX_RES_NONE;
		s_d.rdata_q = 32'h0000_0000;

		// software writes; hardware sets are merged afterwards so they win
		if (i_wr) begin
			if (sel(i_addr, `SFPX_OFF_CTRLSTAT)) begin
				s_d.flags_q = i_wdata[`SFPX_FLAG_MSB:`SFPX_FLAG_LSB];
				s_d.masks_q = i_wdata[`SFPX_MASK_MSB:`SFPX_MASK_LSB];
			end
			if (sel(i_addr, `SFPX_OFF_PFLAGS)) begin
				s_d.if_q = i_wdata[`SFPX_PF_IF_BIT];
			end
			if (sel(i_addr, `SFPX_OFF_IRQ_MSK)) begin
				s_d.irq_msk_q = i_wdata[1:0];
			end
		end

		// interrupt status: events set, write of one clears, set wins
		if (i_wr && sel(i_addr, `SFPX_OFF_IRQ_STS)) begin
			s_d.irq_sts_q = w1c(s_q.irq_sts_q, i_wdata[1:0], irq_set);
		end else begin
			s_d.irq_sts_q = w1c(s_q.irq_sts_q, 2'h0, irq_set);
		end

		// one sticky flag per type, lane identity is lost on purpose
		if (op_take) begin
			s_d.flags_q = s_d.flags_q | raised;
		end

		// masked-only op: default result commits quietly
		if (masked_event || (op_take && raised == `SFPX_FLAG_RST)) begin
			s_d.res_q = sfpx_pkg::SFPX_RES_COMMIT;
		end

		// unmasked: trap at this very instruction, nothing is written back
		if (take_trap) begin
			s_d.trap_q = 1'h1;
			s_d.res_q = sfpx_pkg::SFPX_RES_SUPPRESS;
			s_d.cause_q = unmasked;
			s_d.fault_q = (pre_unmasked != `SFPX_FLAG_RST);
			if (i_gate_is_intr) begin
				s_d.if_q = 1'h0;
				s_d.if_clr_q = 1'h1;
			end
		end

		s_d.irq_q = ((s_d.irq_sts_q & s_d.irq_msk_q) != 2'h0);

		// read data stands in the cycle after the strobe; unmapped reads zero
		if (i_rd) begin
			if (sel(i_addr, `SFPX_OFF_CTRLSTAT)) begin
				s_d.rdata_q = cs_word(s_q.flags_q, s_q.masks_q);
			end
			if (sel(i_addr, `SFPX_OFF_PFLAGS)) begin
				s_d.rdata_q[`SFPX_PF_IF_BIT] = s_q.if_q;
			end
			if (sel(i_addr, `SFPX_OFF_IRQ_STS)) begin
				s_d.rdata_q[1:0] = s_q.irq_sts_q;
			end
			if (sel(i_addr, `SFPX_OFF_IRQ_MSK)) begin
				s_d.rdata_q[1:0] = s_q.irq_msk_q;
			end
			if (sel(i_addr, `SFPX_OFF_TRAP_INFO)) begin
				s_d.rdata_q[`SFPX_TI_CAUSE_MSB:`SFPX_TI_CAUSE_LSB] = s_q.cause_q;
				s_d.rdata_q[`SFPX_TI_FAULT_BIT] = s_q.fault_q;
				s_d.rdata_q[`SFPX_TI_VEC_MSB:`SFPX_TI_VEC_LSB] = `SFPX_TRAP_VECTOR;
			end
		end
	end

	// state register; all exceptions start masked so nothing traps before
	// software has its handler installed
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			s_q.flags_q <= `SFPX_FLAG_RST;
			s_q.masks_q <= `SFPX_MASK_RST;
			s_q.if_q <= `SFPX_PF_IF_RST;
			s_q.irq_sts_q <= 2'h0;
			s_q.irq_msk_q <= `SFPX_IRQ_MSK_RST;
			s_q.cause_q <= `SFPX_FLAG_RST;
			s_q.fault_q <= 1'h0;
			s_q.trap_q <= 1'h0;
			s_q.res_q <= sfpx_pkg::SFPX_RES_NONE;
			s_q.if_clr_q <= 1'h0;
			s_q.irq_q <= 1'h0;
			s_q.rdata_q <= 32'h0000_0000;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from state; the vector register loads 0x00 in reset, then the fixed constant
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_trap_vector <= 8'h00;
		end else begin
			o_trap_vector <= `SFPX_TRAP_VECTOR;
		end
	end

	// no sync stage on op inputs: same-clock pipeline, overlap is free
	assign o_rdata = s_q.rdata_q;
	assign o_trap = s_q.trap_q;
	assign o_trap_cause = s_q.cause_q;
	assign o_trap_fault = s_q.fault_q;
	assign o_res_commit = (s_q.res_q == sfpx_pkg::SFPX_RES_COMMIT);
	assign o_res_suppress = (s_q.res_q == sfpx_pkg::SFPX_RES_SUPPRESS);
	assign o_if_clear = s_q.if_clr_q;
	assign o_irq = s_q.irq_q;
endmodule

// *** sfpx_exc_unit_properties.sv ***
`timescale 1ns/1ps
module sfpx_exc_unit_properties (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_op_valid,
	input wire logic i_op_packed,
	input wire logic [3:0] i_lane_en,
	input wire logic [3:0][5:0] i_lane_exc,
	input wire logic i_gate_is_intr,
	input wire logic o_trap,
	input wire logic [7:0] o_trap_vector,
	input wire logic [5:0] o_trap_cause,
	input wire logic o_trap_fault,
	input wire logic o_res_commit,
	input wire logic o_res_suppress,
	input wire logic o_if_clear
);
	logic [5:0] raised;
	// merged raise set; scalar ops only count lane 0
	always_comb begin
		raised = 6'h00;
		for (int k = 0; k < 4; k++) begin
			if (i_lane_en[k] && (i_op_packed || k == 0)) begin
				raised = raised | i_lane_exc[k];
			end
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	a_one_answer: assert property (i_op_valid && !o_trap |=> o_res_commit ^ o_trap)
		else $error("op answer wrong");
	a_quiet_commit: assert property (i_op_valid && !o_trap && raised == 6'h00 |=> o_res_commit)
		else $error("clean op not committed");
	a_trap_suppress: assert property (o_trap |-> o_res_suppress && !o_res_commit)
		else $error("trap result not suppressed");
	a_trap_vector: assert property (o_trap |-> o_trap_vector == 8'h13)
		else $error("trap vector wrong");
	a_no_lone_trap: assert property (!i_op_valid |=> !o_trap)
		else $error("trap without op");
	a_gate_clear: assert property (o_if_clear |-> o_trap && $past(i_gate_is_intr))
		else $error("enable cleared without gate trap");
	a_fault_class: assert property (o_trap |-> o_trap_fault == ((o_trap_cause & 6'h07) != 6'h00))
		else $error("fault class wrong");
	a_cause_lanes: assert property (o_trap |-> (o_trap_cause & ~$past(raised)) == 6'h00)
		else $error("cause outside raised lanes");
	a_cause_holds: assert property (!o_trap |-> $stable(o_trap_cause))
		else $error("cause changed without trap");
	c_fault: cover property (o_trap && o_trap_fault);
	c_post: cover property (o_trap && !o_trap_fault);
	c_commit: cover property (o_res_commit);
endmodule
bind sfpx_exc_unit sfpx_exc_unit_properties chk (.*);

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	logic i_clk_sys, i_srst, i_op_valid, i_op_packed, i_gate_is_intr, i_wr, i_rd;
	logic [3:0] i_lane_en;
	logic [3:0][5:0] i_lane_exc;
	logic [7:0] i_addr, o_trap_vector;
	logic [31:0] i_wdata, o_rdata;
	logic o_trap, o_trap_fault, o_res_commit, o_res_suppress, o_if_clear, o_irq;
	logic [5:0] o_trap_cause;
	int miscompares = 0;
	int n_tests = 0;
	sfpx_exc_unit uut (.*);
	// free-running system clock
	initial begin
		i_clk_sys = 1'h0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'h0;
	endtask
	// read data lives one cycle only, so sample just after the edge
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk_sys);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'h0;
		#1 ck(o_rdata, e);
	endtask
	// e packs trap, suppress, commit, if clear, fault, cause
	task automatic op(input logic p, input logic [3:0] en, input logic [23:0] x,
		input logic g, input logic [31:0] e);
		@(posedge i_clk_sys);
		i_op_valid <= 1'h1;
		i_op_packed <= p;
		i_lane_en <= en;
		i_lane_exc <= x;
		i_gate_is_intr <= g;
		@(posedge i_clk_sys);
		i_op_valid <= 1'h0;
		#1 ck(32'({o_trap, o_res_suppress, o_res_commit, o_if_clear, o_trap_fault,
			o_trap_cause}), e);
	endtask
	task automatic t_masked;
		op(1'h0, 4'hF, 24'h000060, 1'h1, 32'h100);
		rd(8'h00, 32'h00001FA0);
	endtask
	task automatic t_packed;
		wr(8'h00, 32'h00001F80);
		op(1'h1, 4'h5, 24'h002210, 1'h0, 32'h100);
		rd(8'h00, 32'h00001F92);
	endtask
	task automatic t_fault;
		wr(8'h00, 32'h00001D80);
		wr(8'h04, 32'h00000200);
		wr(8'h0C, 32'h00000003);
		op(1'h0, 4'h1, 24'h000024, 1'h1, 32'h6C4);
		rd(8'h04, 32'h0);
		rd(8'h00, 32'h00001D84);
		rd(8'h10, 32'h00001344);
		ck(32'(o_irq), 32'h1);
	endtask
	// old unmasked flag plus a masked raise must not trap
	task automatic t_sticky;
		op(1'h0, 4'h1, 24'h000020, 1'h1, 32'h144);
		rd(8'h00, 32'h00001DA4);
	endtask
	task automatic t_post;
		wr(8'h00, 32'h00001B80);
		op(1'h1, 4'h9, 24'h200020, 1'h0, 32'h608);
	endtask
	task automatic t_irq;
		rd(8'h08, 32'h3);
		wr(8'h08, 32'h3);
		rd(8'h08, 32'h0);
		ck(32'(o_irq), 32'h0);
		rd(8'h20, 32'h0);
	endtask
	task automatic complete_run;
		if (miscompares == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		{i_op_valid, i_op_packed, i_gate_is_intr, i_wr, i_rd} = 5'h00;
		i_lane_en = 4'h0;
		i_lane_exc = 24'h0;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		i_srst = 1'h1;
		repeat (6) @(posedge i_clk_sys);
		i_srst <= 1'h0;
		rd(8'h00, 32'h00001F80);
		rd(8'h10, 32'h00001300);
		ck(32'(o_trap_vector), 32'h13);
		t_masked();
		t_packed();
		t_fault();
		t_sticky();
		t_post();
		t_irq();
		complete_run();
	end
	// hang guard, far beyond the few dozen cycles needed
	initial begin
		#20000;
		miscompares++;
		complete_run();
	end
endmodule
